// >>> rtl/bwp_pkg.sv
// Operation
// - Jumper no-protect: blocks unprotected after reset
// - Protect bit one protects, zero unprotects with no-protect jumper; other jumper position inverts
// - Unjumpered platform: block write, no interrupt
// - Protected block writes suppressed, others pass
// - All-zero word clears protection and indicator
// - Word 0401 protects block 0, indicator on
// - Sixteen displacements, each defined read/write
// - Hardware base is software base halved
// - Single-bit transfer touches only addressed bit
// - Multibit transfer: LSB to displacement 0
// - I/O reset clears every control bit
package bwp_pkg;

  // Bit I/O space geometry
  localparam int ADDR_W     = 15;
  localparam int DISP_W     = 4;
  localparam int BASE_W     = ADDR_W - DISP_W;
  localparam int NUM_BITS   = 16;

  // Control bit positions
  localparam int WP_FIRST   = 0;
  localparam int NUM_BLOCKS = 4;
  localparam int BLK_SEL_W  = 2;
  localparam int USER_IND   = 10;

  // Memory side widths
  localparam int MEM_AW     = 16;
  localparam int MEM_DW     = 16;

  // Strap encodings
  localparam logic JMP_NO_PROTECT = 1'b0;
  localparam logic PLAT_JUMPERED  = 1'b1;

  // Values after reset
  localparam logic              CTRL_BIT_RST  = 1'b0;
  localparam logic              RDATA_RST     = 1'b0;
  localparam logic              OE_N_RST      = 1'b1;
  localparam logic [3:0]        PROT_RST      = 4'h0;
  localparam logic [MEM_AW-1:0] MEM_ADDR_RST  = 16'h0000;
  localparam logic [MEM_DW-1:0] MEM_DATA_RST  = 16'h0000;

endpackage

// >>> rtl/bwp_ctrl_bit.sv
`timescale 1ns/10ps
module bwp_ctrl_bit
  import bwp_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control
  input  wire logic clr,
  input  wire logic wr_en,
  input  wire logic wr_val,
  // State
  output logic      q
);

  typedef struct packed {
    logic q;
  } bwp_bit_state_t;

  bwp_bit_state_t s_d;
  bwp_bit_state_t s_q;

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.q = CTRL_BIT_RST;
    end else if (wr_en) begin
      s_d.q = wr_val;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q.q <= CTRL_BIT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;

endmodule

// >>> rtl/bwp_top.sv
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module bwp_top
  import bwp_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Board straps
  input  wire logic [BASE_W-1:0]    io_base_switch,
  input  wire logic                 reset_protect_jumper,
  input  wire logic                 interrupt_level_platform,
  // Bit I/O space from the processor
  input  wire logic                 io_reset,
  input  wire logic [ADDR_W-1:0]    bit_addr,
  input  wire logic                 bit_wdata,
  input  wire logic                 bit_wr,
  input  wire logic                 bit_rd,
  output logic                      bit_rdata,
  output logic                      bit_rdata_oe_n,
  // Memory write request from the board decoder
  input  wire logic                 mem_wr_req,
  input  wire logic [BLK_SEL_W-1:0] mem_block_sel,
  input  wire logic [MEM_AW-1:0]    mem_addr,
  input  wire logic [MEM_DW-1:0]    mem_wdata,
  // Memory write toward the storage array
  output logic                      mem_wr_en,
  output logic [MEM_AW-1:0]         mem_wr_addr,
  output logic [MEM_DW-1:0]         mem_wr_data,
  // Status
  output logic [NUM_BLOCKS-1:0]     block_protect,
  output logic                      user_indicator,
  output logic                      wp_violation_irq
);

  typedef struct packed {
    logic                  rdata;
    logic                  rdata_oe_n;
    logic                  wr_en;
    logic [MEM_AW-1:0]     wr_addr;
    logic [MEM_DW-1:0]     wr_data;
    logic [NUM_BLOCKS-1:0] prot;
    logic                  user_ind;
    logic                  viol_irq;
  } bwp_top_state_t;

  bwp_top_state_t s_d;
  bwp_top_state_t s_q;

  logic                  win_hit;
  logic [DISP_W-1:0]     disp;
  logic [NUM_BITS-1:0]   bit_wr_en;
  logic [NUM_BITS-1:0]   ctrl_bits;
  logic [NUM_BLOCKS-1:0] prot_eff;
  logic                  write_blocked;

  assign win_hit = (bit_addr[ADDR_W-1:DISP_W] == io_base_switch);
  assign disp    = bit_addr[DISP_W-1:0];

  // Sixteen stored bits
  // Every displacement is a plain read-back latch, so a multibit load
  // is just a run of single-bit writes at rising displacements.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BITS; gi++) begin : g_bit
      assign bit_wr_en[gi] = bit_wr && win_hit && (disp == DISP_W'(gi));
      bwp_ctrl_bit u_bit (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clr     (io_reset),
        .wr_en   (bit_wr_en[gi]),
        .wr_val  (bit_wdata),
        .q       (ctrl_bits[gi])
      );
    end
  endgenerate

  // Jumper picks polarity
  // With the other jumper position, cleared bits mean protected, so the
  // board comes out of any reset fully protected.
  always_comb begin
    prot_eff = '0;
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      if (reset_protect_jumper == JMP_NO_PROTECT) begin
        prot_eff[i] = ctrl_bits[WP_FIRST + i];
      end else begin
        prot_eff[i] = !ctrl_bits[WP_FIRST + i];
      end
    end
  end

  // Suppress protected writes
  // Gating is on live control bits, so a write right after a protect
  // bit changes already sees the new protection.
  assign write_blocked = mem_wr_req && prot_eff[mem_block_sel];

  always_comb begin
    s_d = s_q;

    s_d.wr_en = mem_wr_req && !write_blocked;
    if (mem_wr_req) begin
      s_d.wr_addr = mem_addr;
      s_d.wr_data = mem_wdata;
    end

    s_d.viol_irq = write_blocked && (interrupt_level_platform == PLAT_JUMPERED);

    s_d.prot     = prot_eff;
    s_d.user_ind = ctrl_bits[USER_IND];

    s_d.rdata      = RDATA_RST;
    s_d.rdata_oe_n = OE_N_RST;
    if (bit_rd && win_hit) begin
      s_d.rdata      = ctrl_bits[disp];
      s_d.rdata_oe_n = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q.rdata      <= RDATA_RST;
      s_q.rdata_oe_n <= OE_N_RST;
      s_q.wr_en      <= 1'b0;
      s_q.wr_addr    <= MEM_ADDR_RST;
      s_q.wr_data    <= MEM_DATA_RST;
      s_q.prot       <= PROT_RST;
      s_q.user_ind   <= CTRL_BIT_RST;
      s_q.viol_irq   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_rdata        = s_q.rdata;
  assign bit_rdata_oe_n   = s_q.rdata_oe_n;
  assign mem_wr_en        = s_q.wr_en;
  assign mem_wr_addr      = s_q.wr_addr;
  assign mem_wr_data      = s_q.wr_data;
  assign block_protect    = s_q.prot;
  assign user_indicator   = s_q.user_ind;
  assign wp_violation_irq = s_q.viol_irq;

endmodule

// >>> bench/bwp_properties.sv
`timescale 1ns/10ps
module bwp_properties
  import bwp_pkg::*;
(
  input wire logic mclk, sys_rst, io_reset, bit_wr, bit_rd, bit_wdata, bit_rdata, bit_rdata_oe_n,
  input wire logic mem_wr_req, mem_wr_en, wp_violation_irq, user_indicator, reset_protect_jumper,
  input wire logic interrupt_level_platform,
  input wire logic [BASE_W-1:0]     io_base_switch,
  input wire logic [ADDR_W-1:0]     bit_addr,
  input wire logic [NUM_BLOCKS-1:0] block_protect
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire w = bit_addr[14:4] == io_base_switch;
  wire v = bit_wr && w && !io_reset;
  a_read_ans: assert property (bit_rd && w |=> !bit_rdata_oe_n)
    else $error("read not answered");
  a_out_quiet: assert property (!w |=> bit_rdata_oe_n)
    else $error("drove line outside window");
  a_idle_low: assert property (bit_rdata_oe_n |-> !bit_rdata)
    else $error("read data while idle");
  a_io_clear: assert property (io_reset && !reset_protect_jumper |-> ##2 !block_protect && !user_indicator)
    else $error("io reset left bits set");
  a_prot_bit: assert property (v && bit_addr[3:2] == 0 && !reset_protect_jumper ##1 !io_reset |=>
    block_protect[$past(bit_addr[1:0], 2)] == $past(bit_wdata, 2))
    else $error("protect bit wrong");
  a_ind_bit: assert property (v && bit_addr[3:0] == 4'hA ##1 !io_reset |=> user_indicator == $past(bit_wdata, 2))
    else $error("indicator wrong");
  a_no_irq: assert property (!interrupt_level_platform |=> !wp_violation_irq)
    else $error("irq without platform");
  a_gate_cause: assert property (mem_wr_en || wp_violation_irq |-> $past(mem_wr_req))
    else $error("gate output without request");
  cover property (mem_wr_req ##1 wp_violation_irq);
  cover property (bit_rd && w ##1 bit_rdata);
  cover property (io_reset);
endmodule

bind bwp_top bwp_properties CHK (.*);

// >>> bench/bwp_cpu.sv
`timescale 1ns/10ps
module bwp_cpu
  import bwp_pkg::*;
#(parameter logic [15:0] SW_BASE = 16'h0900)
(
  input wire logic          mclk,
  output logic [ADDR_W-1:0] bit_addr,
  output logic              bit_wdata, bit_wr, bit_rd, io_reset
);
  initial {bit_addr, bit_wdata, bit_wr, bit_rd, io_reset} = '0;
  // halved base, kept at 0200 or above
  task automatic go(input logic [4:0] d, input logic v, input logic r);
    @(posedge mclk);
    bit_addr <= ADDR_W'(SW_BASE >> 1) + ADDR_W'(d);
    bit_wdata <= v;
    {bit_wr, bit_rd} <= {!r, r};
    @(posedge mclk);
    {bit_wr, bit_rd} <= 2'h0;
    // Released lines flip so a stale value never looks live
    bit_addr <= ~bit_addr;
    bit_wdata <= ~v;
  endtask
  task automatic ld(input logic [15:0] x, input int n);
    for (int i = 0; i < n; i++) go(5'(i), x[i], 1'b0);
  endtask
  task automatic rst;
    @(posedge mclk);
    io_reset <= 1'b1;
    @(posedge mclk);
    io_reset <= 1'b0;
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb;
  import bwp_pkg::*;
  logic              mclk = 0, sys_rst = 1, plat = 0, req = 0, jmp = 0, bw, bwr, brd, ior, rdat, oen, wen, ind, irq;
  logic [1:0]        sel = 0;
  logic [15:0]       ma = 0, md = 0, wd, wa;
  logic [ADDR_W-1:0] ba;
  logic [3:0]        bp;
  int                n_errors = 0, comparisons = 0;
  always #10 mclk = ~mclk;
  bwp_cpu CPU (.mclk(mclk), .bit_addr(ba), .bit_wdata(bw), .bit_wr(bwr), .bit_rd(brd), .io_reset(ior));
  bwp_top DUT (.mclk(mclk), .sys_rst(sys_rst), .io_base_switch(11'h048), .reset_protect_jumper(jmp),
    .interrupt_level_platform(plat), .io_reset(ior), .bit_addr(ba), .bit_wdata(bw), .bit_wr(bwr),
    .bit_rd(brd), .bit_rdata(rdat), .bit_rdata_oe_n(oen), .mem_wr_req(req), .mem_block_sel(sel),
    .mem_addr(ma), .mem_wdata(md), .mem_wr_en(wen), .mem_wr_addr(wa), .mem_wr_data(wd),
    .block_protect(bp), .user_indicator(ind), .wp_violation_irq(irq));
  task chk(input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task mw(input logic [1:0] s, input logic p, input logic [1:0] e);
    @(posedge mclk);
    {req, sel, plat} <= {1'b1, s, p};
    ma <= {s, 14'h0123};
    md <= ~{s, 14'h0123};
    @(posedge mclk);
    req <= 1'b0;
    ma <= ~ma;
    @(negedge mclk);
    chk({wen, irq}, e);
    chk(wd, ~{s, 14'h0123});
    chk(wa, {s, 14'h0123});
  endtask
  task rb(input logic [4:0] d, input logic [1:0] e);
    CPU.go(d, 1'b0, 1'b1);
    @(negedge mclk);
    chk({oen, rdat}, e);
  endtask
  task t_reset;
    for (int d = 0; d < 16; d++) rb(5'(d), 2'h0);
    mw(2'h3, 1'b0, 2'h2);
  endtask
  task t_word;
    CPU.ld(16'hFFFF, 16);
    for (int d = 0; d < 16; d++) rb(5'(d), 2'h1);
    CPU.ld(16'h0000, 16);
    @(negedge mclk);
    chk({ind, bp}, 0);
    mw(2'h0, 1'b0, 2'h2);
    CPU.ld(16'h0401, 16);
    @(negedge mclk);
    chk({ind, bp}, 5'h11);
    mw(2'h0, 1'b1, 2'h1);
    mw(2'h0, 1'b0, 2'h0);
    mw(2'h1, 1'b0, 2'h2);
  endtask
  task t_bits;
    CPU.go(5'h0, 1'b0, 1'b0);
    CPU.go(5'h1, 1'b1, 1'b0);
    rb(5'hA, 2'h1);
    chk(bp, 4'h2);
    CPU.ld(16'h0001, 2);
    rb(5'h0, 2'h1);
    CPU.ld(16'h0002, 2);
    rb(5'h1, 2'h1);
    chk(bp, 4'h2);
  endtask
  task t_edge;
    CPU.go(5'h10, 1'b1, 1'b0);
    rb(5'h10, 2'h2);
    chk(bp, 4'h2);
    CPU.rst;
    rb(5'hA, 2'h0);
    chk({ind, bp}, 0);
  endtask
  // Other jumper position: cleared bits protect, a one unprotects
  task t_jump;
    @(posedge mclk);
    jmp <= 1'b1;
    mw(2'h0, 1'b0, 2'h0);
    CPU.go(5'h2, 1'b1, 1'b0);
    mw(2'h2, 1'b0, 2'h2);
    chk(bp, 4'hB);
  endtask
  task summarize;
    $display("Errors %0d of %0d checks", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_word;
    t_bits;
    t_edge;
    t_jump;
    summarize;
  end
  initial begin
    #40000;
    n_errors++;
    summarize;
  end
endmodule
